// *** rtl/asbd_decoder.sv ***
// asbd_decoder: block decode, chip select, wait control, dram and page-rom strobes
// dma wins when both request at once; a request is latched when it is granted
`timescale 1ns/100ps
module asbd_decoder
    import asbd_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  cpu_valid,     // cpu wants a cycle
    input  wire asbd_req_t             cpu_req,       // cpu request
    input  wire logic                  dma_valid,     // dma controller wants a cycle
    input  wire asbd_req_t             dma_req,       // dma request
    input  wire asbd_blk_cfg_t [3:0]   mem_cfg,       // per-block config, memory space
    input  wire asbd_blk_cfg_t [3:0]   io_cfg,        // per-block config, io space
    input  wire logic [PAGE_SEL_W-1:0] page_sel,      // page width code
    input  wire logic [15:0]           ext_rdata,     // external data bus in
    input  wire logic [DATA_W-1:0]     int_io_rdata,  // on-chip unit read data
    input  wire logic                  int_io_ack,    // on-chip unit finished
    output logic                       cpu_grant,     // cpu request taken
    output logic                       dma_grant,     // dma request taken
    output logic                       done,          // cycle finished pulse
    output logic [DATA_W-1:0]          rdata,         // read data
    output logic [EXT_ADDR_W-1:0]      ext_addr,      // external address pins
    output logic [15:0]                ext_wdata,     // data bus out
    output logic                       ext_data_oe,   // data bus enable
    output logic [NUM_BLK-1:0]         block_select_lines_n, // chip selects, low active
    output logic                       mem_rd_n,      // memory read strobe
    output logic                       mem_wr_lo_n,   // lower-byte memory write
    output logic                       mem_wr_hi_n,   // upper-byte memory write
    output logic                       io_rd_n,       // io read strobe
    output logic                       io_wr_n,       // io write strobe
    output logic                       row_strobe_n,  // dram row strobe
    output logic                       upper_column_strobe_n,
    output logic                       lower_column_strobe_n,
    output logic                       int_io_sel,    // on-chip unit select
    output asbd_req_t                  int_io_req     // request to on-chip units
);
    ////////////////////////////////////////////////////////////////////////
    asbd_state_t       st_q;        // sequencer state
    asbd_req_t         req_q;       // latched request
    logic [1:0]        blk_q;       // decoded block
    logic              int_q;       // cycle goes internal
    asbd_blk_cfg_t     cfg_q;       // config of the addressed block
    logic [WAIT_W-1:0] wcnt_q;      // wait countdown
    logic              half_q;      // second halfword of a word access
    logic [15:0]       lo_q;        // low halfword captured on word reads
    logic              page_upd;    // compare strobe
    logic              on_page;     // page hit
    logic              start;       // new request taken
    asbd_req_t         pick;        // chosen request
    logic [EXT_ADDR_W-1:0] cur_addr;// current external address
    logic              act;         // external beat in progress
    logic [1:0]        ln;          // byte lanes of the current beat

    // block field of a 32-bit address
    function automatic logic [1:0] blk_of(input logic [ADDR_W-1:0] a);
        blk_of = a[BLK_MSB:BLK_LSB];
    endfunction

    // byte lanes of a halfword beat: {upper, lower}
    function automatic logic [1:0] lanes(input logic [1:0] sz, input logic a0);
        lanes = (sz == SZ_BYTE) ? (a0 ? 2'b10 : 2'b01) : 2'b11;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // dma wins over cpu; the cpu is simply held off while dma owns the bus
    assign start     = (st_q == ASBD_IDLE) && (cpu_valid || dma_valid);
    assign dma_grant = start && dma_valid;
    assign cpu_grant = start && !dma_valid;
    assign pick      = dma_valid ? dma_req : cpu_req;
    assign cur_addr  = {req_q.addr[EXT_ADDR_W-1:2], req_q.addr[1] | half_q, req_q.addr[0]};
    assign page_upd  = (st_q == ASBD_ADDR) && !int_q;
    assign act       = (st_q == ASBD_NEXT || st_q == ASBD_WAIT) && !int_q;
    assign ln        = lanes(req_q.size, req_q.addr[0]);

    asbd_page_cmp u_page (
        .clock    (clock),
        .rst      (rst),
        .update   (page_upd),
        .addr     (cur_addr),
        .page_sel (page_sel),
        .kind     (cfg_q.cyc == CYC_DRAM),
        .on_page  (on_page)
    );

    // request latch and block decode
    always_ff @(posedge clock) begin
        if (rst) begin
            req_q <= '0;
            blk_q <= 2'h0;
            int_q <= 1'b0;
            cfg_q <= '0;
        end else if (start) begin
            req_q <= pick;
            blk_q <= blk_of(pick.addr);
            int_q <= pick.is_io && (blk_of(pick.addr) == INT_IO_BLK);
            cfg_q <= pick.is_io ? io_cfg[blk_of(pick.addr)]
                                : mem_cfg[blk_of(pick.addr)];
        end
    end

    // sequencer: addr -> next -> wait -> done (internal cycles skip next), looping once more for external word accesses
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q   <= ASBD_IDLE;
            wcnt_q <= '0;
            half_q <= 1'b0;
        end else begin
            case (st_q)
                ASBD_IDLE: begin
                    half_q <= 1'b0;
                    if (start) st_q <= ASBD_ADDR;
                end
                ASBD_ADDR: begin
                    st_q <= int_q ? ASBD_WAIT : ASBD_NEXT;
                end
                ASBD_NEXT: begin
                    // compare result is ready now; choose page timing
                    wcnt_q <= (cfg_q.cyc != CYC_SRAM && on_page) ? cfg_q.wait_on
                                                                 : cfg_q.wait_off;
                    st_q   <= ASBD_WAIT;
                end
                ASBD_WAIT: begin
                    if (int_q) begin
                        if (int_io_ack) st_q <= ASBD_DONE;
                    end else if (wcnt_q != '0) begin
                        wcnt_q <= wcnt_q - 1'b1;
                    end else if (req_q.size == SZ_WORD && !half_q) begin
                        half_q <= 1'b1;   // second beat on the 16-bit bus
                        st_q   <= ASBD_ADDR;
                    end else begin
                        st_q <= ASBD_DONE;
                    end
                end
                default: st_q <= ASBD_IDLE;
            endcase
        end
    end

    // read data assembly, lower address holds the low-order byte
    always_ff @(posedge clock) begin
        if (rst) begin
            lo_q  <= '0;
            rdata <= '0;
        end else if (st_q == ASBD_WAIT && int_q && int_io_ack) begin
            rdata <= int_io_rdata;
        end else if (st_q == ASBD_WAIT && wcnt_q == '0 && !int_q) begin
            if (req_q.size == SZ_WORD && !half_q) lo_q <= ext_rdata;
            else if (req_q.size == SZ_WORD)       rdata <= {ext_rdata, lo_q};
            else if (req_q.size == SZ_HALF)       rdata <= {16'h0000, ext_rdata};
            else rdata <= {24'h000000, req_q.addr[0] ? ext_rdata[15:8] : ext_rdata[7:0]};
        end
    end

    // pin drivers, registered from the sequencer state
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_addr    <= '0;
            ext_wdata   <= '0;
            ext_data_oe <= 1'b0;
            block_select_lines_n  <= '1;
            mem_rd_n    <= 1'b1;
            mem_wr_lo_n <= 1'b1;
            mem_wr_hi_n <= 1'b1;
            io_rd_n     <= 1'b1;
            io_wr_n     <= 1'b1;
            row_strobe_n          <= 1'b1;
            upper_column_strobe_n <= 1'b1;
            lower_column_strobe_n <= 1'b1;
        end else begin
            ext_addr  <= cur_addr;
            ext_wdata <= half_q ? req_q.wdata[31:16] :
                         (req_q.size == SZ_BYTE) ? {2{req_q.wdata[7:0]}}
                                                 : req_q.wdata[15:0];
            ext_data_oe <= act && req_q.write;
            block_select_lines_n <= act ? ~(4'h1 << blk_q) : 4'hf;
            mem_rd_n    <= !(act && !req_q.is_io && !req_q.write && cfg_q.cyc != CYC_DRAM);
            mem_wr_lo_n <= !(act && !req_q.is_io && req_q.write && ln[0]);
            mem_wr_hi_n <= !(act && !req_q.is_io && req_q.write && ln[1]);
            io_rd_n     <= !(act && req_q.is_io && !req_q.write);
            io_wr_n     <= !(act && req_q.is_io && req_q.write);
            // row opens one cycle before the columns, and the columns open in
            // the first wait cycle so a zero-wait read still has its data out
            row_strobe_n <= !((act || (st_q == ASBD_ADDR && !int_q)) && !req_q.is_io &&
                              cfg_q.cyc == CYC_DRAM);
            upper_column_strobe_n <= !(act && !req_q.is_io &&
                                       cfg_q.cyc == CYC_DRAM && ln[1]);
            lower_column_strobe_n <= !(act && !req_q.is_io &&
                                       cfg_q.cyc == CYC_DRAM && ln[0]);
        end
    end

    // internal io steering and completion
    assign int_io_sel = (st_q == ASBD_WAIT) && int_q;
    assign int_io_req = req_q;
    assign done       = (st_q == ASBD_DONE);

    ////////////////////////////////////////////////////////////////////////
    int_io_cs_a: assert property (@(posedge clock) disable iff (rst)
        int_io_sel |-> block_select_lines_n == 4'hf) else $error("cs on internal io");
    one_cs_a: assert property (@(posedge clock) disable iff (rst)
        $countones(~block_select_lines_n) <= 1) else $error("two chip selects");
    cs_block_a: assert property (@(posedge clock) disable iff (rst)
        (st_q == ASBD_WAIT && !int_q) |=> !block_select_lines_n[blk_q]) else $error("wrong cs");
    int_decode_a: assert property (@(posedge clock) disable iff (rst)
        start |=> int_q == (req_q.is_io && req_q.addr[31:30] == 2'h3)) else $error("io block 3");
    ext_addr_a: assert property (@(posedge clock) disable iff (rst)
        (st_q == ASBD_WAIT && !int_q) |=> ext_addr[23:2] == req_q.addr[23:2]) else $error("addr");
    grant_one_a: assert property (@(posedge clock) disable iff (rst)
        !(cpu_grant && dma_grant)) else $error("double grant");
    done_bound_a: assert property (@(posedge clock) disable iff (rst)
        (start && !(pick.is_io && pick.addr[31:30] == 2'h3)) |-> ##[4:40] done)
        else $error("cycle hung");
    cas_ras_a: assert property (@(posedge clock) disable iff (rst)
        !lower_column_strobe_n |-> !row_strobe_n) else $error("cas without ras");
    byte_lane_a: assert property (@(posedge clock) disable iff (rst)
        (!mem_wr_lo_n && !mem_wr_hi_n) |-> req_q.size != SZ_BYTE) else $error("byte lanes");
    cover_dram_c: cover property (@(posedge clock) !row_strobe_n ##1 !upper_column_strobe_n);
    cover_word_c: cover property (@(posedge clock) st_q == ASBD_WAIT && half_q);
    cover_intio_c: cover property (@(posedge clock) int_io_sel && int_io_ack);
    cover_dma_c:   cover property (@(posedge clock) dma_grant && cpu_valid);
endmodule // asbd_decoder

// *** rtl/asbd_page_cmp.sv ***
// asbd_page_cmp: remembers the previous cycle's address and flags on-page hits
// assumes the caller pulses update at the start of each external bus cycle
`timescale 1ns/100ps
module asbd_page_cmp
    import asbd_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  update,   // capture new address
    input  wire logic [EXT_ADDR_W-1:0] addr,     // current external address
    input  wire logic [PAGE_SEL_W-1:0] page_sel, // page width code
    input  wire logic                  kind,     // 0 sram or rom, 1 dram; tracked apart
    output logic                       on_page   // registered hit flag
);
    logic [EXT_ADDR_W-1:0] prev_q [2];  // last address per memory kind
    logic                  vld_q  [2];  // a previous address is held

    // mask off the in-page bits for the chosen width
    function automatic logic [EXT_ADDR_W-1:0] page_mask(input logic [PAGE_SEL_W-1:0] s);
        page_mask = {EXT_ADDR_W{1'b1}} << (PAGE_MIN_LSB + int'(s));
    endfunction

    // previous address store, one word per kind
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_q[0] <= '0;
            prev_q[1] <= '0;
            vld_q[0]  <= 1'b0;
            vld_q[1]  <= 1'b0;
        end else if (update) begin
            prev_q[kind] <= addr;
            vld_q[kind]  <= 1'b1;
        end
    end

    // hit result registered so the wait logic sees a clean level
    always_ff @(posedge clock) begin
        if (rst) begin
            on_page <= 1'b0;
        end else if (update) begin
            on_page <= vld_q[kind] &&
                       ((addr & page_mask(page_sel)) == (prev_q[kind] & page_mask(page_sel)));
        end
    end
endmodule // asbd_page_cmp

// *** rtl/asbd_pkg.sv ***
// asbd_pkg: shared constants and carrier types for the address-space block decoder
// assumes a 32-bit internal address, a 24-bit external bus and a 16-bit data path
package asbd_pkg;
    localparam int ADDR_W       = 32;  // internal address width
    localparam int EXT_ADDR_W   = 24;  // external address width
    localparam int BLK_MSB      = 31;  // block select field, high bit
    localparam int BLK_LSB      = 30;  // block select field, low bit
    localparam int NUM_BLK      = 4;   // blocks per space
    localparam int DATA_W       = 32;  // cpu side data width
    localparam int WAIT_W       = 4;   // wait count width
    localparam int PAGE_SEL_W   = 2;   // page width code: 8,16,32,64 bytes
    localparam int PAGE_MIN_LSB = 3;   // an 8-byte page leaves bits 2:0 inside it
    localparam logic [1:0] INT_IO_BLK = 2'h3; // io block kept for on-chip units
    localparam logic [1:0] SZ_BYTE  = 2'h0;   // access size codes
    localparam logic [1:0] SZ_HALF  = 2'h1;
    localparam logic [1:0] SZ_WORD  = 2'h2;
    localparam logic [1:0] CYC_SRAM = 2'h0;   // per-block bus cycle types
    localparam logic [1:0] CYC_DRAM = 2'h1;
    localparam logic [1:0] CYC_PROM = 2'h2;

    // one bus request, from the cpu or the dma controller
    typedef struct packed {
        logic              is_io;   // 1: io space, 0: memory space
        logic              write;   // 1: write
        logic [1:0]        size;    // byte, halfword or word
        logic [ADDR_W-1:0] addr;    // 32-bit internal address
        logic [DATA_W-1:0] wdata;   // little-endian write data
    } asbd_req_t;

    // per-block configuration
    typedef struct packed {
        logic [1:0]        cyc;     // bus cycle type
        logic [WAIT_W-1:0] wait_off;// off-page / normal waits
        logic [WAIT_W-1:0] wait_on; // on-page waits
    } asbd_blk_cfg_t;

    // gray along idle -> addr -> next -> wait -> done
    typedef enum logic [2:0] {
        ASBD_IDLE = 3'b000,
        ASBD_ADDR = 3'b001,
        ASBD_NEXT = 3'b011,
        ASBD_WAIT = 3'b010,
        ASBD_DONE = 3'b110
    } asbd_state_t;
endpackage

// *** test/address_space_block_decoder_tb.sv ***
// address_space_block_decoder_tb: random and corner bus cycles through the decoder
// assumes the decoder answers each grant with one done pulse within 200 cycles
`timescale 1ns/100ps
module address_space_block_decoder_tb;
    import asbd_pkg::*;
    logic                  clock, rst, cpu_valid, dma_valid, int_io_ack;
    asbd_req_t             cpu_req, dma_req;
    asbd_blk_cfg_t [3:0]   mem_cfg, io_cfg;
    logic [PAGE_SEL_W-1:0] page_sel;
    logic [15:0]           ext_rdata, ext_wdata;
    logic [DATA_W-1:0]     int_io_rdata, rdata;
    logic                  cpu_grant, dma_grant, done, ext_data_oe, int_io_sel;
    logic [EXT_ADDR_W-1:0] ext_addr;
    logic [NUM_BLK-1:0]    cs_n, cs_seen;         // selects and their history
    logic                  mrd_n, wlo_n, whi_n, iord_n, iowr_n, ras_n, ucol_n, lcol_n;
    logic [7:0]            seen;                  // strobes seen low this cycle
    logic                  busy;                  // monitor window open
    asbd_req_t             int_io_req;
    logic [31:0]           rnd;                   // xorshift state
    int                    failures, samples_checked;

    asbd_decoder i_dut (.clock(clock), .rst(rst), .cpu_valid(cpu_valid), .cpu_req(cpu_req),
        .dma_valid(dma_valid), .dma_req(dma_req), .mem_cfg(mem_cfg), .io_cfg(io_cfg),
        .page_sel(page_sel), .ext_rdata(ext_rdata), .int_io_rdata(int_io_rdata),
        .int_io_ack(int_io_ack), .cpu_grant(cpu_grant), .dma_grant(dma_grant), .done(done),
        .rdata(rdata), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_data_oe(ext_data_oe),
        .block_select_lines_n(cs_n), .mem_rd_n(mrd_n), .mem_wr_lo_n(wlo_n),
        .mem_wr_hi_n(whi_n), .io_rd_n(iord_n), .io_wr_n(iowr_n), .row_strobe_n(ras_n),
        .upper_column_strobe_n(ucol_n), .lower_column_strobe_n(lcol_n),
        .int_io_sel(int_io_sel), .int_io_req(int_io_req));

    asbd_ext_mem i_mem (.clock(clock), .ext_addr(ext_addr),
        .rd_n(mrd_n & iord_n & ucol_n & lcol_n), .ext_rdata(ext_rdata));

    ////////////////////////////////////////////////////////////////////////
    // clock, 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // on-chip unit answers one cycle after it is selected
    always @(posedge clock) int_io_ack <= int_io_sel & ~int_io_ack;

    // monitor: sole owner of the strobe history; cleared on an idle edge
    always @(negedge clock) begin
        if (!busy) begin
            cs_seen <= 4'h0;
            seen    <= 8'h00;
        end else begin
            cs_seen <= cs_seen | ~cs_n;
            seen    <= seen | ~{mrd_n, wlo_n, whi_n, iord_n, iowr_n, ras_n, ucol_n, lcol_n};
            if (cs_n !== 4'hf) check("ext_addr", ext_addr[23:2], cpu_req.addr[23:2]);
            if (ext_data_oe === 1'b1)
                check("ext_wdata", ext_wdata, exp_wd(cpu_req, ext_addr[1]));
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // expected read data: little-endian halfwords from the memory model
    function automatic logic [31:0] exp_rd(input asbd_req_t r);
        logic [15:0] lo, hi;
        lo = r.addr[16:1] ^ 16'h5a3c;
        hi = {r.addr[16:2], 1'b1} ^ 16'h5a3c;
        if (r.size == SZ_WORD) return {hi, lo};
        if (r.size == SZ_HALF) return {16'h0000, lo};
        return {24'h000000, r.addr[0] ? lo[15:8] : lo[7:0]};
    endfunction

    // expected write data on the 16-bit bus; pin bit 1 picks the word half
    function automatic logic [15:0] exp_wd(input asbd_req_t r, input logic a1);
        if (r.size == SZ_WORD) return a1 ? r.wdata[31:16] : r.wdata[15:0];
        if (r.size == SZ_HALF) return r.wdata[15:0];
        return {2{r.wdata[7:0]}};
    endfunction

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // one bus cycle: who 0 cpu, 1 dma, 2 both raised together
    task automatic run(input int who, input asbd_req_t r);
        logic [1:0] b;
        logic       intl;
        logic [1:0] cyc;
        int         n;
        b    = r.addr[BLK_MSB:BLK_LSB];
        intl = r.is_io && (b == INT_IO_BLK);
        @(negedge clock);                      // idle edge: monitor clears its history
        cyc  = r.is_io ? io_cfg[b].cyc : mem_cfg[b].cyc; // config updates have landed
        @(posedge clock);
        cpu_req <= r; dma_req <= r; busy <= 1'b1;
        cpu_valid <= (who != 1); dma_valid <= (who != 0);
        n = 0;
        do begin @(negedge clock); n++; end while (!(cpu_grant | dma_grant) && n < 200);
        if (n >= 200) begin failures++; summarize(); end
        if (who == 2) check("dma first", {cpu_grant, dma_grant}, 32'h1);
        @(posedge clock);
        cpu_valid <= 1'b0; dma_valid <= 1'b0;
        n = 0;
        do begin @(negedge clock); n++; end while (done !== 1'b1 && n < 200);
        if (n >= 200) begin failures++; summarize(); end
        @(negedge clock); busy <= 1'b0;
        check("selects", cs_seen, intl ? 4'h0 : 4'h1 << b);
        if (intl) begin
            check("int rdata", rdata, int_io_rdata);
            check("int req", int_io_req.addr, r.addr);
        end else if (!r.write) begin
            check("rdata", r.size == SZ_BYTE ? rdata[7:0] : r.size == SZ_HALF ? rdata[15:0]
                : rdata, exp_rd(r));
            if (r.is_io) check("io rd", seen[4], 1'b1);
            else if (cyc == CYC_DRAM) check("dram", {seen[2], seen[1] | seen[0]}, 2'h3);
            else check("mem rd", seen[7], 1'b1);
        end else if (r.is_io) begin
            check("io wr", seen[3], 1'b1);
        end else begin
            check("mem wr", cyc == CYC_DRAM ? seen[2] : seen[6] | seen[5], 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, corners, then random traffic
    initial begin
        asbd_req_t r;
        rst = 1'b1; cpu_valid = 1'b0; dma_valid = 1'b0; busy = 1'b0;
        cpu_req = '0; dma_req = '0; page_sel = 2'h0; int_io_rdata = 32'h0000_0000;
        failures = 0; samples_checked = 0; rnd = 32'h1c63;
        for (int i = 0; i < 4; i++) begin
            mem_cfg[i] = '{cyc: i % 3, wait_off: 4'h2, wait_on: 4'h1};
            io_cfg[i]  = '{cyc: CYC_SRAM, wait_off: 4'h1, wait_on: 4'h0};
        end
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        run(2, '{1'b1, 1'b0, SZ_WORD, 32'hc000_0010, 32'h0});
        run(0, '{1'b0, 1'b0, SZ_BYTE, 32'hffff_ffff, 32'h0});
        run(1, '{1'b0, 1'b0, SZ_HALF, 32'h4000_0100, 32'h0});
        run(1, '{1'b0, 1'b0, SZ_HALF, 32'h4000_0102, 32'h0});
        run(0, '{1'b0, 1'b0, SZ_WORD, 32'h8012_3454, 32'h0});
        for (int i = 0; i < 120; i++) begin
            rnd = xs(rnd); r.addr = rnd;
            rnd = xs(rnd); r.wdata = rnd; r.size = rnd[1:0] % 3;
            r.is_io = rnd[8]; r.write = rnd[9] & !(rnd[8] && r.addr[31:30] == INT_IO_BLK);
            if (r.size == SZ_WORD) r.addr[1:0] = 2'h0;
            if (r.size == SZ_HALF) r.addr[0] = 1'b0;
            int_io_rdata <= rnd ^ 32'h3c3c_a5a5;
            page_sel <= rnd[17:16];
            mem_cfg[rnd[19:18]] <= '{cyc: rnd[21:20] % 3, wait_off: rnd[23:22], wait_on: 4'h0};
            io_cfg[rnd[25:24]].wait_off <= rnd[27:26];
            run(rnd[29:28] % 3, r);
        end
        summarize();
    end
endmodule // address_space_block_decoder_tb

// *** test/asbd_ext_mem.sv ***
// asbd_ext_mem: behavioural external memory/io device on the 16-bit data bus
// assumes rd_n is the and of every read-type strobe of the decoder
`timescale 1ns/100ps
module asbd_ext_mem
    import asbd_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic [EXT_ADDR_W-1:0] ext_addr,  // address pins
    input  wire logic                  rd_n,      // any read strobe, low active
    output logic      [15:0]           ext_rdata  // data bus towards the decoder
);
    logic [15:0] last_q; // last value driven, for the released bus

    initial last_q = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // read data is a pure function of the halfword address; a released bus
    // shows the inverse of the last value so stale data never matches
    assign ext_rdata = !rd_n ? (ext_addr[16:1] ^ 16'h5a3c) : ~last_q;

    // remember the last driven value
    always @(posedge clock) begin
        if (!rd_n) begin
            last_q <= ext_rdata;
        end
    end
endmodule // asbd_ext_mem
